// File: verilog/rxe_mii_rx.sv
`default_nettype none

// Elastic store for recovered nibbles
module rxe_fifo #(
	parameter int unsigned W     = 7,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];   // Storage array
	logic [AW:0]  wr_q;            // Write pointer, extra wrap bit
	logic [AW:0]  rd_q;            // Read pointer, extra wrap bit
	logic         push;            // Accepted write
	logic         pop;             // Accepted read
	logic         full;            // No room left
	logic         empty;           // Nothing stored

	assign full      = (wr_q[AW] != rd_q[AW]) &&
		(wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// Storage has no reset; only pointers define contents
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointer update
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule

// Receive side of the MAC-facing nibble interface
module rxe_mii_rx
	import rxe_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       line_clk,
	input  wire logic       line_crs,
	input  wire logic       line_link,
	input  wire logic       line_speed_100,
	input  wire logic [3:0] line_nib,
	input  wire logic       line_sof,
	input  wire logic       line_eof,
	input  wire logic       line_err,
	input  wire logic       receive_float_request,
	output logic            rx_clk,
	output logic            rx_clk_oe_n,
	output logic      [3:0] rxd,
	output logic            rxd_oe_n,
	output logic            rx_dv,
	output logic            rx_dv_oe_n,
	output logic            rx_er,
	output logic            rx_er_oe_n,
	output logic            line_ready
);
	localparam int unsigned PW = 12;

	// Pin synchronisers; stage one is read only by stage two
	logic [PW-1:0] pin_raw;        // Raw pins, packed
	logic [PW-1:0] pin_s1_q;       // First stage
	logic [PW-1:0] pin_s2_q;       // Second stage, safe to use
	logic          lclk_d_q;       // Delayed line clock for edges

	// Synchronised names
	logic          lclk_s;         // Line clock
	logic          crs_s;          // Carrier
	logic          link_s;         // Link established
	logic          speed_s;        // 100 Mb/s selected
	logic          float_s;        // MAC float request
	rxe_ent_t      ent_s;          // Line nibble and marks
	logic          lclk_rise;      // Line nibble strobe

	// Receive clock generator
	logic [DIV_W-1:0] div_q;       // Half period counter
	logic [DIV_W-1:0] div_d;
	logic [DIV_W-1:0] half_sel;    // Half period for the speed
	logic          rclk_q;         // Receive clock level
	logic          rclk_d;
	logic          half_end;       // Last cycle of a half period
	logic          fall_evt;       // Receive clock falls now
	logic          realign;        // Restart the clock phase
	logic          link_q;         // Link seen last cycle
	logic          link_rise;      // Link just came up

	// Frame handling
	rxe_state_t    state_q;        // Frame state
	rxe_state_t    state_d;
	rxe_mii_t      mii_q;          // Registered receive outputs
	rxe_mii_t      mii_d;
	logic          float_q;        // Registered float state
	logic          ready_q;        // Registered store ready
	logic          lock_entry;     // Carrier starts a frame

	// Store connections
	logic          st_in_ready;    // Store can take a nibble
	logic          st_out_valid;   // Store holds a nibble
	rxe_ent_t      st_out;         // Oldest nibble
	logic          pop;            // Consume oldest nibble

	assign pin_raw = {line_clk, line_crs, line_link, line_speed_100,
		receive_float_request, line_err, line_eof, line_sof, line_nib};

	// Two flip-flops on every pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			lclk_d_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			lclk_d_q <= pin_s2_q[11];
		end
	end

	// Data and clock share the same latency, so a nibble settles
	// well before its strobe edge is seen at slow line rates
	assign lclk_s    = pin_s2_q[11];
	assign crs_s     = pin_s2_q[10];
	assign link_s    = pin_s2_q[9];
	assign speed_s   = pin_s2_q[8];
	assign float_s   = pin_s2_q[7];
	assign ent_s     = rxe_ent_t'(pin_s2_q[6:0]);
	assign lclk_rise = lclk_s && !lclk_d_q;

	// Line nibbles enter on each line clock rising edge within carrier while the store is not full
	rxe_fifo #(
		.W     ($bits(rxe_ent_t)),
		.DEPTH (FIFO_DEPTH)
	) u_store (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (lclk_rise && crs_s),
		.in_ready  (st_in_ready),
		.in_data   (ent_s),
		.out_valid (st_out_valid),
		.out_ready (pop),
		.out_data  (st_out)
	);

	// Half period picked by speed
	assign half_sel  = speed_s ? HALF_100 : HALF_10;
	// A speed change can leave the count past the new end point;
	// ending there avoids a long wrap through the whole counter
	assign half_end  = (div_q >= half_sel - DIV_W'(1));
	assign link_rise = link_s && !link_q;
	assign lock_entry = (state_q == RXE_IDLE) && crs_s;

	// 10M: once per packet, inside carrier-before-valid window.
	// 100M: once at link up; the phase may jump a full cycle.
	assign realign = speed_s ? link_rise
		: lock_entry;
	assign fall_evt = half_end && rclk_q && !realign;

	// Without link the divider free-runs from the reference clock
	always_comb begin
		div_d  = div_q + DIV_W'(1);
		rclk_d = rclk_q;
		if (realign) begin
			div_d  = DIV_RST;
			rclk_d = 1'b1;
		end else if (half_end) begin
			div_d  = DIV_RST;
			rclk_d = !rclk_q;
		end
	end

	// Receive clock registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_q  <= DIV_RST;
			rclk_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			rclk_q <= rclk_d;
			link_q <= link_s;
		end
	end

	// Outputs only move on the falling edge, a half period
	// ahead of the rising edge where the MAC samples
	assign pop = fall_evt && st_out_valid;

	// Frame state and output selection
	always_comb begin
		state_d = state_q;
		mii_d   = mii_q;
		if (fall_evt) begin
			mii_d.er = 1'b0;
			case (state_q)
				RXE_IDLE: begin
					mii_d = MII_RST;
				end
				RXE_LOCK: begin
					// Delimiter found: first nibble goes valid
					if (pop && st_out.sof) begin
						state_d   = RXE_DATA;
						mii_d.dv  = 1'b1;
						mii_d.er  = st_out.err && speed_s;
						mii_d.rxd = st_out.nib;
					end else if (pop && st_out.err && speed_s) begin
						// False carrier shows as error, not valid
						mii_d.er  = 1'b1;
						mii_d.rxd = FALSE_CARRIER_NIB;
					end else if (!pop && !crs_s) begin
						state_d = RXE_IDLE;
					end
				end
				RXE_DATA: begin
					if (pop && !st_out.eof) begin
						mii_d.rxd = st_out.nib;
						mii_d.er  = st_out.err && speed_s;
					end else begin
						// End delimiter, or store ran dry: abort
						state_d = RXE_IDLE;
						mii_d   = MII_RST;
					end
				end
				default: begin
					state_d = RXE_IDLE;
					mii_d   = MII_RST;
				end
			endcase
		end else if (lock_entry) begin
			state_d = RXE_LOCK;
		end
	end

	// Frame state registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= RXE_IDLE;
			mii_q   <= MII_RST;
			float_q <= 1'b1;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			mii_q   <= mii_d;
			float_q <= float_s;
			ready_q <= st_in_ready;
		end
	end

	// Float request from the MAC side releases rx_clk, rxd, rx_dv and rx_er; line_ready stays driven
	assign rx_clk      = rclk_q;
	assign rxd         = mii_q.rxd;
	assign rx_dv       = mii_q.dv;
	assign rx_er       = mii_q.er;
	assign rx_clk_oe_n = float_q;
	assign rxd_oe_n    = float_q;
	assign rx_dv_oe_n  = float_q;
	assign rx_er_oe_n  = float_q;
	assign line_ready  = ready_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_half_10;
		!speed_s && !realign && div_q == HALF_10 - DIV_W'(1)
			|=> rclk_q != $past(rclk_q);
	endproperty
	a_half_10: assert property (p_half_10)
		else $error("10M receive clock half period wrong");

	property p_half_100;
		speed_s && $stable(speed_s) && !realign && !half_end
			|=> div_q == $past(div_q) + DIV_W'(1) && div_q < HALF_100;
	endproperty
	a_half_100: assert property (p_half_100)
		else $error("100M receive clock divider out of range");

	property p_realign_10;
		realign && !speed_s |-> state_q == RXE_IDLE && !mii_q.dv
			##1 state_q == RXE_LOCK && rclk_q && div_q == DIV_RST;
	endproperty
	a_realign_10: assert property (p_realign_10)
		else $error("10M realign outside carrier window");

	property p_realign_100;
		realign && speed_s |-> link_s && !link_q
			##1 rclk_q && div_q == DIV_RST;
	endproperty
	a_realign_100: assert property (p_realign_100)
		else $error("100M realign without link bring-up");

	property p_float;
		float_s |=> rx_clk_oe_n && rxd_oe_n && rx_dv_oe_n && rx_er_oe_n;
	endproperty
	a_float: assert property (p_float)
		else $error("Outputs driven during float request");

	property p_dv_edge;
		$changed(rx_dv) |-> $past(fall_evt) && !rx_clk;
	endproperty
	a_dv_edge: assert property (p_dv_edge)
		else $error("Valid changed away from falling edge");

	property p_sof;
		$rose(rx_dv) |-> $past(pop) && $past(st_out.sof)
			&& $past(state_q) == RXE_LOCK;
	endproperty
	a_sof: assert property (p_sof)
		else $error("Valid asserted without start delimiter");

	property p_eof;
		state_q == RXE_DATA && pop && st_out.eof |=> !rx_dv ##1 !rx_dv;
	endproperty
	a_eof: assert property (p_eof)
		else $error("Valid held past end delimiter");

	property p_er_10;
		!speed_s && $stable(speed_s) |=> !rx_er;
	endproperty
	a_er_10: assert property (p_er_10)
		else $error("Receive error raised in 10M mode");

	property p_er_edge;
		$changed(rx_er) |-> $past(fall_evt);
	endproperty
	a_er_edge: assert property (p_er_edge)
		else $error("Receive error changed off the clock edge");
endmodule
`default_nettype wire

// File: common/rxe_pkg.sv
`default_nettype none
package rxe_pkg;
	// Core clock and the two receive clock rates
	localparam int unsigned CORE_HZ      = 200_000_000;
	localparam int unsigned RXCLK_10_HZ  = 2_500_000;
	localparam int unsigned RXCLK_100_HZ = 25_000_000;

	// Half periods of the receive clock in core cycles
	localparam int unsigned DIV_W = 7;
	localparam logic [DIV_W-1:0] HALF_10 =
		DIV_W'(CORE_HZ / (2 * RXCLK_10_HZ));
	localparam logic [DIV_W-1:0] HALF_100 =
		DIV_W'(CORE_HZ / (2 * RXCLK_100_HZ));
	localparam logic [DIV_W-1:0] DIV_RST = 7'h00;

	// Values after reset and special nibbles
	localparam logic [3:0] NIB_RST           = 4'h0;
	localparam logic [3:0] FALSE_CARRIER_NIB = 4'he;

	// Elastic store between line and receive clock
	localparam int unsigned FIFO_DEPTH = 16;

	// One recovered nibble with its delimiter and error marks
	typedef struct packed {
		logic       err;
		logic       eof;
		logic       sof;
		logic [3:0] nib;
	} rxe_ent_t;

	// Receive interface outputs travelling together
	typedef struct packed {
		logic [3:0] rxd;
		logic       dv;
		logic       er;
	} rxe_mii_t;

	localparam rxe_mii_t MII_RST = '{rxd: NIB_RST, dv: 1'b0, er: 1'b0};

	// Frame state, one-hot
	typedef enum logic [2:0] {
		RXE_IDLE = 3'b001,
		RXE_LOCK = 3'b010,
		RXE_DATA = 3'b100
	} rxe_state_t;
endpackage
`default_nettype wire

// File: verification/rxe_mac_model.sv
`default_nettype none

// MAC side of the receive nibble interface: samples on clock rise
module rxe_mac_model
	import rxe_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             rx_clk,
	input  wire logic       [3:0] rxd,
	input  wire logic             rx_dv,
	input  wire logic             rx_er,
	output logic      [DIV_W-1:0] half_len
);
	timeunit 1ns;
	timeprecision 1ps;

	logic             clk_q;      // Receive clock one core cycle ago
	logic [DIV_W-1:0] run_q;      // Core cycles since last clock edge
	rxe_mii_t         seen_q[$];  // Samples taken with valid or error

	// Edge finder and sampler; a floated clock (z) restarts the half period count but never counts as sampling edge
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clk_q <= 1'b0;
			run_q <= '0;
			half_len <= '0;
		end else begin
			clk_q <= rx_clk;
			// Restart the half period count on any level change
			if (rx_clk !== clk_q) begin
				run_q <= DIV_W'(1);
				half_len <= run_q;
			end else begin
				run_q <= run_q + 1'b1;
			end
			// Take the nibble only at the rising edge
			if (rx_clk === 1'b1 && clk_q === 1'b0 &&
				(rx_dv === 1'b1 || rx_er === 1'b1)) begin
				seen_q.push_back('{rxd: rxd, dv: rx_dv, er: rx_er});
			end
		end
	end
endmodule

`default_nettype wire

// File: verification/rxe_mii_rx_test.sv
`default_nettype none

// Self-checking bench for the receive nibble interface
module rxe_mii_rx_test
	import rxe_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk, rst, line_clk, line_crs, line_link;
	logic       line_speed_100, line_sof, line_eof, line_err;
	logic [3:0] line_nib, rxd;
	logic       receive_float_request, rx_clk, rx_dv, rx_er, line_ready;
	logic       rx_clk_oe_n, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n;
	logic [DIV_W-1:0] half_len;    // Measured half period
	rxe_mii_t   exp_q[$];          // Reference model of expected samples
	int         errors, num_checks, cycles;
	logic       saw_full;          // Store refused a nibble at least once

	// Pin levels as the MAC sees them; released pins float
	wire       mac_clk = rx_clk_oe_n ? 1'bz : rx_clk;
	wire [3:0] mac_rxd = rxd_oe_n ? 4'hz : rxd;
	wire       mac_dv  = rx_dv_oe_n ? 1'bz : rx_dv;
	wire       mac_er  = rx_er_oe_n ? 1'bz : rx_er;

	rxe_mii_rx dut (.core_clk(core_clk), .rst(rst), .line_clk(line_clk),
		.line_crs(line_crs), .line_link(line_link),
		.line_speed_100(line_speed_100), .line_nib(line_nib),
		.line_sof(line_sof), .line_eof(line_eof), .line_err(line_err),
		.receive_float_request(receive_float_request), .rx_clk(rx_clk),
		.rx_clk_oe_n(rx_clk_oe_n), .rxd(rxd), .rxd_oe_n(rxd_oe_n),
		.rx_dv(rx_dv), .rx_dv_oe_n(rx_dv_oe_n), .rx_er(rx_er),
		.rx_er_oe_n(rx_er_oe_n), .line_ready(line_ready));

	rxe_mac_model mac (.core_clk(core_clk), .rst(rst), .rx_clk(mac_clk),
		.rxd(mac_rxd), .rx_dv(mac_dv), .rx_er(mac_er),
		.half_len(half_len));

	// 200 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Hang guard, well above the longest sequence
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			results();
		end
	end

	// One comparison, counted; mismatch printed at once
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One line nibble; line clock idles low and stalls while store is full
	task automatic send_nib(input logic [3:0] nib, input logic sof,
		input logic eof, input logic err);
		int n;
		n = 0;
		while (line_ready !== 1'b1 && n < 4000) begin
			saw_full = 1'b1;
			n++;
			@(posedge core_clk);
		end
		@(posedge core_clk);
		line_nib <= nib;
		line_sof <= sof;
		line_eof <= eof;
		line_err <= err;
		#32 line_clk <= 1'b1;
		#32 line_clk <= 1'b0;
	endtask

	// Wait for the MAC samples, then compare with the reference model
	task automatic compare_all();
		int n;
		rxe_mii_t s;
		n = 0;
		while (mac.seen_q.size() < exp_q.size() && n < 5000) begin
			n++;
			@(posedge core_clk);
		end
		repeat (200) @(posedge core_clk);
		check(8'(mac.seen_q.size()), 8'(exp_q.size()));
		while (exp_q.size() > 0 && mac.seen_q.size() > 0) begin
			s = mac.seen_q.pop_front();
			check({2'h0, s}, {2'h0, exp_q.pop_front()});
		end
		mac.seen_q.delete();
		exp_q.delete();
	endtask

	// Preamble, start-marked frame of random nibbles, end marker
	task automatic frame(input int len, input logic spd);
		logic [3:0] v;
		logic       e;
		@(posedge core_clk);
		line_crs <= 1'b1;
		// Nibbles before the start marker never reach the MAC
		send_nib(4'h5, 1'b0, 1'b0, 1'b0);
		send_nib(4'h5, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < len; i++) begin
			v = 4'($urandom);
			e = (i == len - 1);
			send_nib(v, i == 0, 1'b0, e);
			// Error flag carried only at 100 Mb/s
			exp_q.push_back('{rxd: v, dv: 1'b1, er: e & spd});
		end
		send_nib(4'h0, 1'b0, 1'b1, 1'b0);
		compare_all();
		@(posedge core_clk);
		line_crs <= 1'b0;
		repeat (200) @(posedge core_clk);
	endtask

	// Main sequence
	initial begin
		errors = 0;
		num_checks = 0;
		cycles = 0;
		saw_full = 1'b0;
		rst = 1'b1;
		line_clk = 1'b0;
		line_crs = 1'b0;
		line_link = 1'b1;
		line_speed_100 = 1'b0;
		line_nib = 4'h0;
		line_sof = 1'b0;
		line_eof = 1'b0;
		line_err = 1'b0;
		receive_float_request = 1'b0;
		void'($urandom(32'h94e5));
		repeat (4) @(posedge core_clk);
		// All outputs quiet and released in reset
		check({4'h0, rx_clk, rx_dv, rx_er, line_ready}, 8'h00);
		check({4'h0, rxd}, {4'h0, NIB_RST});
		check({rx_clk_oe_n, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, 8'h0f);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		// Float request releases every receive pin, then drives again
		receive_float_request <= 1'b1;
		repeat (8) @(posedge core_clk);
		check({rx_clk_oe_n, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, 8'h0f);
		receive_float_request <= 1'b0;
		repeat (8) @(posedge core_clk);
		check({rx_clk_oe_n, rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, 8'h00);
		// Both speeds: clock rate, frame (long at 10 Mb/s, one nibble at 100 Mb/s), false carrier
		for (int sp = 0; sp < 2; sp++) begin
			line_speed_100 <= sp[0];
			repeat (400) @(posedge core_clk);
			check(8'(half_len), 8'(sp ? HALF_100 : HALF_10));
			// At 100 Mb/s the line is slower than the clock: short frame
			frame(sp ? 1 : 20, sp[0]);
			@(posedge core_clk);
			line_crs <= 1'b1;
			send_nib(4'h3, 1'b0, 1'b0, 1'b1);
			if (sp == 1)
				exp_q.push_back('{rxd: FALSE_CARRIER_NIB, dv: 1'b0,
					er: 1'b1});
			compare_all();
			line_crs <= 1'b0;
			repeat (100) @(posedge core_clk);
		end
		check({7'h0, saw_full}, 8'h01);
		// Without a link the clock keeps the 100 Mb/s rate
		line_link <= 1'b0;
		repeat (400) @(posedge core_clk);
		check(8'(half_len), 8'(HALF_100));
		// Link comes back: one realign, then the same rate
		line_link <= 1'b1;
		repeat (400) @(posedge core_clk);
		check(8'(half_len), 8'(HALF_100));
		results();
	end
endmodule

`default_nettype wire
